// >>> hw/fbp_map.svh
/*
  register offsets, field positions, reset values and timing counts
  for the flash block protection controller.
  assumes a byte-addressed plain register port (offsets in steps of 4).
*/
`ifndef FBP_MAP_SVH
`define FBP_MAP_SVH

`define FBP_OFS_PROG_PERMIT   8'h00
`define FBP_OFS_READ_PERMIT   8'h04
`define FBP_OFS_USEC_RELOAD   8'h08
`define FBP_OFS_TARGET_ADDR   8'h0C
`define FBP_OFS_WRITE_DATA    8'h10
`define FBP_OFS_CONTROL       8'h14
`define FBP_OFS_IRQ_MASK      8'h18
`define FBP_OFS_RAW_STATUS    8'h1C
`define FBP_OFS_COMMITTED_PP  8'h20
`define FBP_OFS_COMMITTED_RP  8'h24

`define FBP_CTL_WRITE         0
`define FBP_CTL_ERASE         1
`define FBP_CTL_COMMIT        3

`define FBP_ST_PROG_DONE      0
`define FBP_ST_ACCESS_VIOL    1
`define FBP_ST_READ_FAULT     2

`define FBP_PERMIT_RESET      32'hFFFF_FFFF
`define FBP_USEC_RESET        8'h31
`define FBP_BLOCK_BYTES       1024
`define FBP_UNIT_BYTES        2048
`define FBP_WORDS_PER_BLOCK   256

// operation length in microseconds, counted with usec_reload
`define FBP_PROG_US           16'h0014
`define FBP_ERASE_US          16'h0014
`define FBP_COMMIT_US         16'h0004

`endif

// >>> hw/fbp_pkg.sv
/*
  types for the flash block protection controller.
  assumes fbp_map.svh constants are visible to the user module.
*/
package fbp_pkg;

  typedef enum logic [1:0] {
    FBP_IDLE   = 2'b00,
    FBP_PROG   = 2'b01,
    FBP_ERASE  = 2'b10,
    FBP_COMMIT = 2'b11
  } fbp_state_t;

  // register-port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } fbp_reg_req_t;

  // flash read request from a core path
  typedef struct packed {
    logic [14:0] addr;   // byte address within the flash
    logic        req;
  } fbp_fetch_t;

  // answer to a core path
  typedef struct packed {
    logic [31:0] data;
    logic        valid;
    logic        fault;
  } fbp_resp_t;

  // sram bit alias request
  typedef struct packed {
    logic [17:0] alias_ofs;  // offset from the alias base
    logic        wr;
    logic        wbit;
    logic        req;
  } fbp_alias_t;

endpackage : fbp_pkg

// >>> hw/fbp_ctrl.sv
/*
  flash block protection controller: flash array in flip-flops, timed
  program, erase and commit, per-unit read and program permission,
  and single-bit alias access to a small sram.
  assumes the core drives one-cycle requests on clk_sys, separate paths
  for fetch, data and debugger reads; sram and flash are small models.
*/
// The register addresses and the strobed register port are this design's own decisions.
//Contract
//- flash is made of 1 KB erase blocks; erase sets every bit to one
//- program one 32-bit word, only turning ones to zeros
//- protection unit is 2 KB, a pair of erase blocks
//- two 32-bit registers, one bit per unit per policy
//- execute-only units refuse program/erase, allow only instruction fetch; code gates program/erase on program permit only
//- execute-only units unreadable by core data and debugger
//- program and erase timed by cycles-per-microsecond reload value
//- program permit one allows change; zero keeps contents
//- read permit one allows reads; zero allows execution only
//- program one, read zero: write, erase, execute, no data read
//- program zero, read one: read, execute, no write or erase
//- both ones: no restriction
//- refused data read raises bus fault to the core
//- refused program/erase raises access interrupt when mask set
//- core data reads, literal loads included, refused on execute-only
//- read permit zero refuses every data read from any source
//- software can only clear permit bits, never set them
//- uncommitted clears return on power-on reset; commits persist; code also resets committed copies to all ones
//- sram bit alias at byte offset times 32 plus bit times 4
//- commit selects register by target address bit zero
//- commit request bit clears when the commit completes
//- program-complete event on each program or erase finish
//- fetches held off while program or erase is in progress
`include "fbp_map.svh"

module fbp_ctrl #(
  parameter int UNITS     = 16,
  parameter int SRAM_BYTES = 64
) (
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  input  wire fbp_pkg::fbp_reg_req_t reg_req,
  output logic [31:0]               reg_rdata,
  input  wire fbp_pkg::fbp_fetch_t  ifetch,
  input  wire fbp_pkg::fbp_fetch_t  dread,
  input  wire fbp_pkg::fbp_fetch_t  dbg_read,
  output fbp_pkg::fbp_resp_t        ifetch_resp,
  output fbp_pkg::fbp_resp_t        dread_resp,
  output fbp_pkg::fbp_resp_t        dbg_resp,
  input  wire fbp_pkg::fbp_alias_t  bit_alias,
  output logic                      alias_rdata,
  output logic                      access_irq,
  output logic                      prog_irq,
  output logic                      busy
);

  localparam int WORDS = UNITS * 2 * `FBP_WORDS_PER_BLOCK;
  localparam int WA    = $clog2(WORDS);

  initial begin
    if (UNITS < 1 || UNITS > 32 || SRAM_BYTES < 1 || SRAM_BYTES > 8192)
      $error("fbp_ctrl: unsupported UNITS or SRAM_BYTES");
  end

  typedef struct packed {
    fbp_pkg::fbp_state_t     state;
    logic [31:0]             pp_live;    // program permit, soft copy
    logic [31:0]             rp_live;    // read permit, soft copy
    logic [31:0]             pp_commit;  // committed program permit
    logic [31:0]             rp_commit;  // committed read permit
    logic [7:0]              usec;
    logic [31:0]             taddr;
    logic [31:0]             wdata;
    logic [3:0]              ctl;
    logic [1:0]              irq_mask;
    logic [2:0]              raw;
    logic [7:0]              usec_cnt;
    logic [15:0]             us_cnt;
    logic [31:0]             rdata;
    fbp_pkg::fbp_resp_t      iresp;
    fbp_pkg::fbp_resp_t      dresp;
    fbp_pkg::fbp_resp_t      gresp;
    logic                    ardata;
    logic                    airq;
    logic                    pirq;
    logic                    busy;
  } st_t;

  st_t s_r;
  st_t s_nxt;
  logic [31:0] flash_r [WORDS];
  logic [7:0]  sram_r  [SRAM_BYTES];

  // unit index of a byte address: two 1 KB blocks per unit
  function automatic logic [4:0] unit_of(input logic [31:0] a);
    unit_of = a[15:11];
  endfunction : unit_of

  function automatic logic [WA-1:0] word_of(input logic [31:0] a);
    word_of = a[WA+1:2];
  endfunction : word_of

  // microsecond tick: prescaler count at zero, reloaded from the reload value
  function automatic logic usec_tick(input st_t s);
    usec_tick = (s.usec_cnt == 8'h00);
  endfunction : usec_tick

  logic [31:0] fl_word_i;
  logic [31:0] fl_word_d;
  logic [31:0] fl_word_g;
  logic        do_prog;
  logic        do_erase;
  logic        do_alias_wr;

  always_comb begin
    fl_word_i = flash_r[word_of({17'h0_0000, ifetch.addr})];
    fl_word_d = flash_r[word_of({17'h0_0000, dread.addr})];
    fl_word_g = flash_r[word_of({17'h0_0000, dbg_read.addr})];
  end

  // next-state: register port, sequencer, permission checks
  always_comb begin
    logic        pp_ok;
    logic [31:0] alias_byte;
    logic [4:0]  ubit;
    pp_ok       = 1'b0;
    alias_byte  = 32'h0000_0000;
    ubit        = 5'h00;
    s_nxt       = s_r;
    do_prog     = 1'b0;
    do_erase    = 1'b0;
    do_alias_wr = 1'b0;
    s_nxt.airq  = 1'b0;
    s_nxt.pirq  = 1'b0;
    s_nxt.iresp = '0;
    s_nxt.dresp = '0;
    s_nxt.gresp = '0;
    s_nxt.rdata = 32'h0000_0000;

    // register reads: data in the following cycle only
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        `FBP_OFS_PROG_PERMIT:  s_nxt.rdata = s_r.pp_live;
        `FBP_OFS_READ_PERMIT:  s_nxt.rdata = s_r.rp_live;
        `FBP_OFS_USEC_RELOAD:  s_nxt.rdata = {24'h00_0000, s_r.usec};
        `FBP_OFS_TARGET_ADDR:  s_nxt.rdata = s_r.taddr;
        `FBP_OFS_WRITE_DATA:   s_nxt.rdata = s_r.wdata;
        `FBP_OFS_CONTROL:      s_nxt.rdata = {28'h000_0000, s_r.ctl};
        `FBP_OFS_IRQ_MASK:     s_nxt.rdata = {30'h0000_0000, s_r.irq_mask};
        `FBP_OFS_RAW_STATUS:   s_nxt.rdata = {29'h0000_0000, s_r.raw};
        `FBP_OFS_COMMITTED_PP: s_nxt.rdata = s_r.pp_commit;
        `FBP_OFS_COMMITTED_RP: s_nxt.rdata = s_r.rp_commit;
        default:               s_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // register writes
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        // writes only clear; ones written leave bits as they are
        `FBP_OFS_PROG_PERMIT:
          s_nxt.pp_live = s_r.pp_live & reg_req.wdata;
        `FBP_OFS_READ_PERMIT:
          s_nxt.rp_live = s_r.rp_live & reg_req.wdata;
        `FBP_OFS_USEC_RELOAD: s_nxt.usec = reg_req.wdata[7:0];
        `FBP_OFS_TARGET_ADDR: s_nxt.taddr = reg_req.wdata;
        `FBP_OFS_WRITE_DATA:  s_nxt.wdata = reg_req.wdata;
        `FBP_OFS_CONTROL: begin
          // a new command is ignored while one is running
          if (s_r.state == fbp_pkg::FBP_IDLE) begin
            s_nxt.ctl = reg_req.wdata[3:0];
          end
        end
        `FBP_OFS_IRQ_MASK:    s_nxt.irq_mask = reg_req.wdata[1:0];
        `FBP_OFS_RAW_STATUS:  s_nxt.raw = s_r.raw & ~reg_req.wdata[2:0];
        default: ;
      endcase
    end

    // microsecond prescaler runs only while an operation is timed
    if (s_r.state != fbp_pkg::FBP_IDLE) begin
      s_nxt.usec_cnt = usec_tick(s_r) ? s_r.usec : s_r.usec_cnt - 8'h01;
    end

    ubit  = unit_of(s_r.taddr);
    pp_ok = s_r.pp_live[ubit];
    unique case (s_r.state)
      fbp_pkg::FBP_IDLE: begin
        s_nxt.usec_cnt = s_r.usec;
        if (s_r.ctl[`FBP_CTL_COMMIT]) begin
          s_nxt.state  = fbp_pkg::FBP_COMMIT;
          s_nxt.us_cnt = `FBP_COMMIT_US;
        end else if (s_r.ctl[`FBP_CTL_WRITE] || s_r.ctl[`FBP_CTL_ERASE]) begin
          if (pp_ok) begin
            s_nxt.state  = s_r.ctl[`FBP_CTL_WRITE] ? fbp_pkg::FBP_PROG
                                                   : fbp_pkg::FBP_ERASE;
            s_nxt.us_cnt = s_r.ctl[`FBP_CTL_WRITE] ? `FBP_PROG_US
                                                   : `FBP_ERASE_US;
          end else begin
            // refused: flash untouched, raw flag always set
            s_nxt.ctl = 4'h0;
            s_nxt.raw[`FBP_ST_ACCESS_VIOL] = 1'b1;
            s_nxt.airq = s_r.irq_mask[`FBP_ST_ACCESS_VIOL];
          end
        end
      end
      fbp_pkg::FBP_PROG, fbp_pkg::FBP_ERASE, fbp_pkg::FBP_COMMIT: begin
        if (usec_tick(s_r)) begin
          s_nxt.us_cnt = s_r.us_cnt - 16'h0001;
        end
        if (usec_tick(s_r) && s_r.us_cnt == 16'h0001) begin
          s_nxt.state = fbp_pkg::FBP_IDLE;
          s_nxt.ctl   = 4'h0;
          if (s_r.state == fbp_pkg::FBP_COMMIT) begin
            if (s_r.taddr[0]) begin
              s_nxt.pp_commit = s_r.pp_live;
            end else begin
              s_nxt.rp_commit = s_r.rp_live;
            end
          end else begin
            do_prog  = (s_r.state == fbp_pkg::FBP_PROG);
            do_erase = (s_r.state == fbp_pkg::FBP_ERASE);
            s_nxt.raw[`FBP_ST_PROG_DONE] = 1'b1;
            s_nxt.pirq = s_r.irq_mask[`FBP_ST_PROG_DONE];
          end
        end
      end
    endcase
    s_nxt.busy = (s_nxt.state != fbp_pkg::FBP_IDLE);

    // instruction fetch ignores read permit; held while flash is busy
    if (ifetch.req && s_r.state == fbp_pkg::FBP_IDLE) begin
      s_nxt.iresp.valid = 1'b1;
      s_nxt.iresp.data  = fl_word_i;
    end
    // core data path, literal loads included, needs read permit
    if (dread.req && s_r.state == fbp_pkg::FBP_IDLE) begin
      if (s_r.rp_live[unit_of({17'h0_0000, dread.addr})]) begin
        s_nxt.dresp.valid = 1'b1;
        s_nxt.dresp.data  = fl_word_d;
      end else begin
        s_nxt.dresp.fault = 1'b1;
        s_nxt.raw[`FBP_ST_READ_FAULT] = 1'b1;
      end
    end
    // debugger is a data reader too
    if (dbg_read.req) begin
      if (s_r.rp_live[unit_of({17'h0_0000, dbg_read.addr})]) begin
        s_nxt.gresp.valid = 1'b1;
        s_nxt.gresp.data  = fl_word_g;
      end else begin
        s_nxt.gresp.fault = 1'b1;
      end
    end

    // bit alias: offset / 32 is the byte, offset[4:2] the bit
    alias_byte  = {19'h0_0000, bit_alias.alias_ofs[17:5]};
    s_nxt.ardata = 1'b0;
    if (bit_alias.req) begin
      s_nxt.ardata = sram_r[alias_byte[$clog2(SRAM_BYTES)-1:0]]
                           [bit_alias.alias_ofs[4:2]];
      do_alias_wr  = bit_alias.wr;
    end
  end

  // state register; permits and committed copies return to all ones on power-on reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_r           <= '0;
      s_r.pp_live   <= `FBP_PERMIT_RESET;
      s_r.rp_live   <= `FBP_PERMIT_RESET;
      s_r.pp_commit <= `FBP_PERMIT_RESET;
      s_r.rp_commit <= `FBP_PERMIT_RESET;
      s_r.usec      <= `FBP_USEC_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // arrays: no reset, contents survive; a real part keeps commits in
  // nonvolatile cells, here the committed copy resets to all ones
  always_ff @(posedge clk_sys) begin
    if (do_prog) begin
      flash_r[word_of(s_r.taddr)] <=
        flash_r[word_of(s_r.taddr)] & s_r.wdata;
    end
    if (do_erase) begin
      for (int i = 0; i < `FBP_WORDS_PER_BLOCK; i++) begin
        // block base keeps the word index width; no bits widen or drop
        flash_r[(word_of(s_r.taddr) & ~WA'(255)) + WA'(i)]
          <= 32'hFFFF_FFFF;
      end
    end
    if (do_alias_wr) begin
      sram_r[bit_alias.alias_ofs[$clog2(SRAM_BYTES)+4:5]]
            [bit_alias.alias_ofs[4:2]] <= bit_alias.wbit;
    end
  end

  assign reg_rdata   = s_r.rdata;
  assign ifetch_resp = s_r.iresp;
  assign dread_resp  = s_r.dresp;
  assign dbg_resp    = s_r.gresp;
  assign alias_rdata = s_r.ardata;
  assign access_irq  = s_r.airq;
  assign prog_irq    = s_r.pirq;
  assign busy        = s_r.busy;

endmodule : fbp_ctrl

// >>> sim/fbp_ctrl_sva.sv
/* port assertions for fbp_ctrl, attached by bind.
   assumes one clock domain and reset_n async active low. */
`include "fbp_map.svh"
module fbp_ctrl_sva (
  input wire logic                  clk_sys,
  input wire logic                  reset_n,
  input wire fbp_pkg::fbp_reg_req_t reg_req,
  input wire fbp_pkg::fbp_fetch_t   ifetch,
  input wire fbp_pkg::fbp_fetch_t   dread,
  input wire fbp_pkg::fbp_fetch_t   dbg_read,
  input wire fbp_pkg::fbp_resp_t    ifetch_resp,
  input wire fbp_pkg::fbp_resp_t    dread_resp,
  input wire fbp_pkg::fbp_resp_t    dbg_resp,
  input wire logic                  access_irq,
  input wire logic                  prog_irq,
  input wire logic                  busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_BUSY_START: assert property ($rose(busy) |->
    $past(reg_req.wr && reg_req.addr == `FBP_OFS_CONTROL, 2))
    else $error("busy rose without a control write");
  AST_BUSY_MIN: assert property ($rose(busy) |-> busy[*3])
    else $error("operation ended too early");
  AST_FETCH_HOLD: assert property (ifetch.req && busy |=>
    !ifetch_resp.valid) else $error("fetch answered while busy");
  AST_FETCH_OK: assert property (ifetch.req && !busy |=>
    ifetch_resp.valid && !ifetch_resp.fault)
    else $error("idle fetch not answered");
  AST_DREAD_CAUSE: assert property (dread_resp.valid ||
    dread_resp.fault |-> $past(dread.req))
    else $error("data answer without request");
  AST_FAULT_ALONE: assert property (dread_resp.fault |->
    !dread_resp.valid) else $error("fault and valid together");
  AST_DBG_ANSWER: assert property (dbg_read.req |=>
    dbg_resp.valid != dbg_resp.fault)
    else $error("debugger read not answered once");
  AST_ACCESS_PULSE: assert property (access_irq |->
    !busy ##1 !access_irq) else $error("access pulse malformed");
  AST_PROG_DONE: assert property (prog_irq |->
    $past(busy) || $past(busy, 2)) else $error("done without operation");

  // main scenarios reached
  cover property (dread_resp.fault);
  cover property (access_irq);
  cover property (prog_irq);
  cover property ($rose(busy));
endmodule : fbp_ctrl_sva

bind fbp_ctrl fbp_ctrl_sva chk_u (
  .clk_sys(clk_sys), .reset_n(reset_n), .reg_req(reg_req),
  .ifetch(ifetch), .dread(dread), .dbg_read(dbg_read),
  .ifetch_resp(ifetch_resp), .dread_resp(dread_resp),
  .dbg_resp(dbg_resp), .access_irq(access_irq),
  .prog_irq(prog_irq), .busy(busy)
);

// >>> sim/fbp_core_model.sv
/* core side model: instruction path, data path and debugger reads.
   assumes one request at a time, answer one cycle after it is taken. */
module fbp_core_model (
  input  wire logic                clk_sys,
  output fbp_pkg::fbp_fetch_t      ifetch,
  output fbp_pkg::fbp_fetch_t      dread,
  output fbp_pkg::fbp_fetch_t      dbg_read,
  input  wire fbp_pkg::fbp_resp_t  ifetch_resp,
  input  wire fbp_pkg::fbp_resp_t  dread_resp,
  input  wire fbp_pkg::fbp_resp_t  dbg_resp
);
  timeunit 1ns;
  timeprecision 1ps;
  // paths idle from time zero
  initial begin
    ifetch = '0;
    dread = '0;
    dbg_read = '0;
  end

  // path 0 fetch, 1 data, 2 debugger; address flipped on release so a
  // stale address is never mistaken for a held one
  task automatic access(input int path, input logic [14:0] addr,
                        output fbp_pkg::fbp_resp_t r);
    @(posedge clk_sys);
    if (path == 0) ifetch <= {addr, 1'b1};
    else if (path == 1) dread <= {addr, 1'b1};
    else dbg_read <= {addr, 1'b1};
    @(posedge clk_sys);
    ifetch <= {~addr, 1'b0};
    dread <= {~addr, 1'b0};
    dbg_read <= {~addr, 1'b0};
    @(negedge clk_sys);
    r = (path == 0) ? ifetch_resp : (path == 1) ? dread_resp : dbg_resp;
  endtask : access
endmodule : fbp_core_model

// >>> sim/fbp_ctrl_tb_top.sv
/* self-checking bench for fbp_ctrl with the core model as partner.
   assumes 125 MHz clk_sys and the offsets of fbp_map.svh. */
`include "fbp_map.svh"
module fbp_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk_sys, reset_n, alias_rdata;
  logic                  access_irq, prog_irq, busy, prog_seen, acc_seen;
  logic [31:0]           reg_rdata, rd;
  fbp_pkg::fbp_reg_req_t reg_req;
  fbp_pkg::fbp_fetch_t   ifetch, dread, dbg_read;
  fbp_pkg::fbp_resp_t    ifetch_resp, dread_resp, dbg_resp, r;
  fbp_pkg::fbp_alias_t   bit_alias;
  int                    error_cnt, total_checks;

  fbp_ctrl dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .ifetch(ifetch), .dread(dread),
    .dbg_read(dbg_read), .ifetch_resp(ifetch_resp),
    .dread_resp(dread_resp), .dbg_resp(dbg_resp), .bit_alias(bit_alias),
    .alias_rdata(alias_rdata), .access_irq(access_irq),
    .prog_irq(prog_irq), .busy(busy));
  fbp_core_model core_u (.clk_sys(clk_sys), .ifetch(ifetch),
    .dread(dread), .dbg_read(dbg_read), .ifetch_resp(ifetch_resp),
    .dread_resp(dread_resp), .dbg_resp(dbg_resp));

  initial begin
    clk_sys = 0;
    forever #4 clk_sys = ~clk_sys;
  end
  // interrupt pulses last one cycle, so latch them for the tasks
  always @(posedge clk_sys) begin
    if (prog_irq === 1'b1) prog_seen <= 1;
    if (access_irq === 1'b1) acc_seen <= 1;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
      error_cnt++;
    end
  endtask : check
  task automatic reg_wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_req <= {a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    reg_req.wr <= 0;
  endtask : reg_wr
  task automatic reg_rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_req <= {a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk_sys);
    reg_req.rd <= 0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : reg_rd
  // bounded wait for the end of a timed operation
  task automatic wait_idle();
    // the sequencer picks up a control write one edge after it lands
    repeat (2) @(negedge clk_sys);
    for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(negedge clk_sys);
    @(negedge clk_sys);
    if (busy !== 1'b0) begin
      error_cnt++;
      final_report();
    end
  endtask : wait_idle
  task automatic flash_op(logic [31:0] ctl, logic [14:0] a, logic [31:0] d);
    reg_wr(`FBP_OFS_WRITE_DATA, d);
    reg_wr(`FBP_OFS_TARGET_ADDR, {17'h0_0000, a});
    reg_wr(`FBP_OFS_CONTROL, ctl);
    wait_idle();
  endtask : flash_op
  task automatic t_reset();
    reg_rd(`FBP_OFS_PROG_PERMIT, rd); check("pp", rd, 32'hFFFF_FFFF);
    reg_rd(`FBP_OFS_READ_PERMIT, rd); check("rp", rd, 32'hFFFF_FFFF);
    reg_rd(`FBP_OFS_USEC_RELOAD, rd); check("us", rd, 32'h0000_0031);
    reg_wr(`FBP_OFS_USEC_RELOAD, 32'h0000_007C); // 125 MHz minus one
    reg_rd(`FBP_OFS_USEC_RELOAD, rd); check("us", rd, 32'h0000_007C);
    $display("test reset done");
  endtask : t_reset
  task automatic t_program();
    reg_wr(`FBP_OFS_IRQ_MASK, 32'h0000_0003);
    prog_seen = 0;
    flash_op(32'h0000_0002, 15'h0400, 32'h0000_0000);
    check("done", {31'h0, prog_seen}, 32'h0000_0001);
    core_u.access(1, 15'h07FC, r); check("er", r.data, 32'hFFFF_FFFF);
    flash_op(32'h0000_0001, 15'h0404, 32'hA5A5_0F0F);
    core_u.access(1, 15'h0404, r); check("pg", r.data, 32'hA5A5_0F0F);
    flash_op(32'h0000_0001, 15'h0404, 32'hFFFF_00FF);
    core_u.access(1, 15'h0404, r); check("pg", r.data, 32'hA5A5_000F);
    reg_wr(`FBP_OFS_CONTROL, 32'h0000_0002);
    core_u.access(0, 15'h0404, r); check("hold", {r.valid, r.fault}, 0);
    wait_idle();
    $display("test program done");
  endtask : t_program
  task automatic t_protect();
    flash_op(32'h0000_0002, 15'h0800, 32'h0000_0000);
    flash_op(32'h0000_0001, 15'h0800, 32'h1234_0000);
    reg_wr(`FBP_OFS_RAW_STATUS, 32'h0000_0007);
    reg_wr(`FBP_OFS_READ_PERMIT, 32'hFFFF_FFFD);
    core_u.access(0, 15'h0800, r); check("xo", r.data, 32'h1234_0000);
    check("xo_vf", {r.valid, r.fault}, 2);
    core_u.access(1, 15'h0800, r); check("dr", {r.valid, r.fault}, 1);
    core_u.access(2, 15'h0800, r); check("dbg", {r.valid, r.fault}, 1);
    reg_wr(`FBP_OFS_PROG_PERMIT, 32'hFFFF_FFFD);
    acc_seen = 0;
    flash_op(32'h0000_0002, 15'h0800, 32'h0000_0000);
    check("acc", {31'h0, acc_seen}, 32'h0000_0001);
    core_u.access(0, 15'h0800, r); check("keep", r.data, 32'h1234_0000);
    reg_rd(`FBP_OFS_RAW_STATUS, rd); check("raw", rd, 32'h0000_0006);
    reg_wr(`FBP_OFS_RAW_STATUS, 32'h0000_0007);
    flash_op(32'h0000_0002, 15'h0C00, 32'h0000_0000);
    reg_rd(`FBP_OFS_RAW_STATUS, rd); check("pair", rd, 32'h0000_0002);
    reg_wr(`FBP_OFS_PROG_PERMIT, 32'hFFFF_FFFF);
    reg_rd(`FBP_OFS_PROG_PERMIT, rd); check("set", rd, 32'hFFFF_FFFD);
    $display("test protect done");
  endtask : t_protect
  task automatic t_commit();
    flash_op(32'h0000_0008, 15'h0001, 32'h0000_0000);
    reg_rd(`FBP_OFS_CONTROL, rd); check("ctl", rd, 32'h0000_0000);
    reg_rd(`FBP_OFS_COMMITTED_PP, rd); check("cpp", rd, 32'hFFFF_FFFD);
    flash_op(32'h0000_0008, 15'h0000, 32'h0000_0000);
    reg_rd(`FBP_OFS_COMMITTED_RP, rd); check("crp", rd, 32'hFFFF_FFFD);
    reset_n <= 0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1;
    reg_rd(`FBP_OFS_READ_PERMIT, rd); check("por", rd, 32'hFFFF_FFFF);
    $display("test commit done");
  endtask : t_commit
  // one alias access; ofs is byte times 32 plus bit times 4
  task automatic alias_op(logic [17:0] ofs, logic w, logic b);
    @(posedge clk_sys);
    bit_alias <= {ofs, w, b, 1'b1};
    @(posedge clk_sys);
    bit_alias <= {~ofs, 1'b0, ~b, 1'b0};
    @(negedge clk_sys);
  endtask : alias_op
  task automatic t_alias();
    alias_op(18'h0_00A8, 1, 0);
    alias_op(18'h0_00AC, 1, 1);
    alias_op(18'h0_00AC, 0, 0); check("b3", {31'h0, alias_rdata}, 1);
    alias_op(18'h0_00A8, 0, 0); check("b2", {31'h0, alias_rdata}, 0);
    $display("test alias done");
  endtask : t_alias

  // main sequence: reset, then each scenario in turn
  initial begin
    reset_n = 0;
    reg_req = '0;
    bit_alias = '0;
    prog_seen = 0;
    acc_seen = 0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1;
    t_reset();
    t_program();
    t_protect();
    t_commit();
    t_alias();
    final_report();
  end
endmodule : fbp_ctrl_tb_top
